// ==== hdl/serial_reg_port.sv ====
module serial_reg_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // serial pins, data is open drain
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // device side
  input  wire logic [7:0]  statusIn,
  output logic      [31:0] cfgWord,
  output logic             hsMode
);
  import serial_port_pkg::*;

  reg_bank_if bankBus ();

  logic [1:0]       sclSync_reg;
  logic [1:0]       sdaSync_reg;
  logic             sclDly_reg;
  logic             sdaDly_reg;
  logic             sclRise;
  logic             sclFall;
  logic             startCond;
  logic             stopCond;
  seq_state_t       state_reg;
  logic [3:0]       bitCnt_reg;
  logic [7:0]       shift_reg;
  logic [7:0]       txShift_reg;
  logic [7:0]       regPtr_reg;
  logic             sdaOe_reg;
  logic             hsMode_reg;
  logic             wrEn_reg;
  logic             byteDone;
  logic             receiving;

  // ----------------------------------------------------------------
  // pin sampling and condition detection
  // ----------------------------------------------------------------
  // no filtering: a glitch on the clock line counts as an edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclSync_reg <= 2'h3;
      sdaSync_reg <= 2'h3;
      sclDly_reg  <= 1'b1;
      sdaDly_reg  <= 1'b1;
    end else begin
      sclSync_reg <= {sclSync_reg[0], scl};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclDly_reg  <= sclSync_reg[1];
      sdaDly_reg  <= sdaSync_reg[1];
    end
  end

  assign sclRise   = sclSync_reg[1] & ~sclDly_reg;
  assign sclFall   = ~sclSync_reg[1] & sclDly_reg;
  assign startCond = sclSync_reg[1] & sclDly_reg & sdaDly_reg & ~sdaSync_reg[1];
  assign stopCond  = sclSync_reg[1] & sclDly_reg & ~sdaDly_reg & sdaSync_reg[1];

  assign receiving = (state_reg == ST_DEVADDR) || (state_reg == ST_REGADDR) ||
                     (state_reg == ST_WDATA) || (state_reg == ST_RDATA);
  assign byteDone  = sclFall && (bitCnt_reg == BIT_LAST);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else if (stopCond) begin
      state_reg <= ST_IDLE;
    end else if (startCond) begin
      state_reg <= ST_DEVADDR;
    end else if (sclFall) begin
      case (state_reg)
        ST_DEVADDR: begin
          if (byteDone) begin
            if (shift_reg[7:3] == MCODE_PREFIX) begin
              state_reg <= ST_IGNORE;
            end else if (shift_reg[7:1] == DEV_ADDR) begin
              state_reg <= ST_DEVACK;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        ST_DEVACK:  state_reg <= shift_reg[0] ? ST_RDATA : ST_REGADDR;
        ST_REGADDR: if (byteDone) state_reg <= ST_REGACK;
        ST_REGACK:  state_reg <= ST_WDATA;
        ST_WDATA:   if (byteDone) state_reg <= ST_WACK;
        ST_WACK:    state_reg <= ST_REGADDR;
        ST_RDATA:   if (byteDone) state_reg <= ST_RACK;
        ST_RACK:    state_reg <= shift_reg[0] ? ST_IGNORE : ST_RDATA;
        ST_IGNORE:  state_reg <= ST_IGNORE;
        ST_IDLE:    state_reg <= ST_IDLE;
        default:    state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bit counter and receive shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_reg <= 4'h0;
    end else if (startCond || stopCond || (sclFall && !receiving)) begin
      bitCnt_reg <= 4'h0;
    end else if (sclRise && receiving && bitCnt_reg != BIT_LAST) begin
      bitCnt_reg <= bitCnt_reg + 4'h1;
    end
  end

  // master acknowledge in a read lands in bit 0 for the next decision;
  // our own acknowledge bits must not shift the write data before commit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= 8'h00;
    end else if (sclRise && ((receiving && state_reg != ST_RDATA) || state_reg == ST_RACK)) begin
      shift_reg <= {shift_reg[6:0], sdaSync_reg[1]};
    end
  end

  // ----------------------------------------------------------------
  // register pointer; auto-steps after each byte read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regPtr_reg <= 8'h00;
    end else if (sclFall && state_reg == ST_REGADDR && byteDone) begin
      regPtr_reg <= shift_reg;
    end else if (sclFall && state_reg == ST_RDATA && byteDone) begin
      // steps at byte end so the registered read port settles before the next load
      regPtr_reg <= regPtr_reg + 8'h01;
    end
  end

  // read data loaded at the fall before its first bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txShift_reg <= 8'hff;
    end else if (sclFall && (state_reg == ST_DEVACK || state_reg == ST_RACK)) begin
      txShift_reg <= bankBus.rdData;
    end else if (sclFall && state_reg == ST_RDATA && !byteDone) begin
      txShift_reg <= {txShift_reg[6:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // data line drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaOe_reg <= 1'b0;
    end else if (startCond || stopCond) begin
      sdaOe_reg <= 1'b0;
    end else if (sclFall) begin
      case (state_reg)
        ST_DEVADDR: sdaOe_reg <= byteDone && shift_reg[7:1] == DEV_ADDR
                                 && shift_reg[7:3] != MCODE_PREFIX;
        ST_REGADDR: sdaOe_reg <= byteDone;
        ST_WDATA:   sdaOe_reg <= byteDone;
        ST_DEVACK:  sdaOe_reg <= shift_reg[0] && !bankBus.rdData[7];
        ST_RDATA:   sdaOe_reg <= !byteDone && !txShift_reg[6];
        ST_RACK:    sdaOe_reg <= !shift_reg[0] && !bankBus.rdData[7];
        default:    sdaOe_reg <= 1'b0;
      endcase
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_reg;

  // ----------------------------------------------------------------
  // speed mode; timing is margin-free up to 3.4 Mbps at this clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hsMode_reg <= 1'b0;
    end else if (stopCond) begin
      hsMode_reg <= 1'b0;
    end else if (sclFall && state_reg == ST_DEVADDR && byteDone
                 && shift_reg[7:3] == MCODE_PREFIX) begin
      hsMode_reg <= 1'b1;
    end
  end

  assign hsMode = hsMode_reg;

  // ----------------------------------------------------------------
  // register write at the falling edge ending the data acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrEn_reg <= 1'b0;
    end else begin
      wrEn_reg <= sclFall && state_reg == ST_WACK && !stopCond && !startCond;
    end
  end

  assign bankBus.wrEn   = wrEn_reg;
  assign bankBus.addr   = regPtr_reg;
  assign bankBus.wrData = shift_reg;

  reg_bank reg_bank_i (
    .clk      (clk),
    .reset_n  (reset_n),
    .acc      (bankBus.bank),
    .statusIn (statusIn),
    .cfgWord  (cfgWord)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_start_enters_addr : assert property (startCond && !stopCond |=>
    state_reg == ST_DEVADDR && bitCnt_reg == 4'h0)
    else $error("start did not begin address phase");
  a_stop_releases_bus : assert property (stopCond |=>
    state_reg == ST_IDLE && !sdaOe_reg)
    else $error("stop did not release the bus");
  a_ack_needs_match : assert property ($rose(state_reg == ST_DEVACK) |->
    shift_reg[7:1] == DEV_ADDR && sdaOe_reg)
    else $error("address acknowledged without match");
  a_ack_holds_high : assert property (state_reg == ST_DEVACK && sclSync_reg[1] |->
    sdaOe_reg)
    else $error("acknowledge not held through clock high");
  a_bit_counting : assert property (sclRise && receiving && bitCnt_reg < BIT_LAST |=>
    bitCnt_reg == $past(bitCnt_reg) + 4'h1)
    else $error("bit counter did not advance");
  a_mcode_no_ack : assert property ($rose(hsMode_reg) |->
    !sdaOe_reg && state_reg == ST_IGNORE)
    else $error("master code was acknowledged");
  a_stop_ends_hs : assert property (stopCond |=> !hsMode_reg)
    else $error("stop left high-speed mode set");
  a_write_on_fall : assert property (wrEn_reg |->
    $past(state_reg) == ST_WACK && $past(sclFall) ##1 state_reg == ST_REGADDR)
    else $error("write not tied to acknowledge fall");
  a_write_then_regaddr : assert property (wrEn_reg |-> ##[1:2] state_reg == ST_REGADDR)
    else $error("next byte not taken as register address");
  a_nomatch_released : assert property (state_reg == ST_IGNORE |-> !sdaOe_reg)
    else $error("data driven after address mismatch");

  c_write_done  : cover property (wrEn_reg);
  c_hs_entered  : cover property ($rose(hsMode_reg));
  c_read_byte   : cover property (state_reg == ST_RACK);
  c_no_match    : cover property ($rose(state_reg == ST_IGNORE) && !hsMode_reg);

endmodule : serial_reg_port

// ==== shared/serial_port_pkg.sv ====
package serial_port_pkg;

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR     = 7'h6a;
  localparam logic [4:0] MCODE_PREFIX = 5'h01;
  localparam logic [3:0] BIT_LAST     = 4'h8;

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  localparam int         NUM_REGS     = 5;
  localparam logic [7:0] REG_LIMIT    = 8'h05;
  localparam logic [7:0] RO_INDEX     = 8'h03;
  localparam logic [7:0] UNMAPPED_VAL = 8'hff;
  localparam logic [7:0] RESET_REG0   = 8'h40;
  localparam logic [7:0] RESET_REG1   = 8'h30;
  localparam logic [7:0] RESET_REG2   = 8'h00;
  localparam logic [7:0] RESET_REG4   = 8'h00;

  // ----------------------------------------------------------------
  // serial sequencer states, gray along the write path except the ST_WACK to ST_REGADDR return
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEVADDR = 4'h1,
    ST_DEVACK  = 4'h3,
    ST_REGADDR = 4'h2,
    ST_REGACK  = 4'h6,
    ST_WDATA   = 4'h7,
    ST_WACK    = 4'h5,
    ST_RDATA   = 4'h4,
    ST_RACK    = 4'hc,
    ST_IGNORE  = 4'hd
  } seq_state_t;

endpackage : serial_port_pkg

// ==== shared/reg_bank_if.sv ====
interface reg_bank_if;
  logic       wrEn;
  logic [7:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;

  modport ctrl (output wrEn, output addr, output wrData, input rdData);
  modport bank (input wrEn, input addr, input wrData, output rdData);
endinterface : reg_bank_if

// ==== hdl/reg_bank.sv ====
module reg_bank (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // access from the serial sequencer
  reg_bank_if.bank        acc,
  // device side
  input  wire logic [7:0] statusIn,
  output logic      [31:0] cfgWord
);
  import serial_port_pkg::*;

  logic [7:0] mem_reg [NUM_REGS];

  // ----------------------------------------------------------------
  // storage; the read-only slot shows live status instead
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_reg[0] <= RESET_REG0;
      mem_reg[1] <= RESET_REG1;
      mem_reg[2] <= RESET_REG2;
      mem_reg[3] <= 8'h00;
      mem_reg[4] <= RESET_REG4;
    end else begin
      if (acc.wrEn && acc.addr < REG_LIMIT && acc.addr != RO_INDEX) begin
        mem_reg[acc.addr[2:0]] <= acc.wrData;
      end
      mem_reg[3] <= statusIn;
    end
  end

  // ----------------------------------------------------------------
  // registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc.rdData <= UNMAPPED_VAL;
    end else if (acc.addr < REG_LIMIT) begin
      acc.rdData <= mem_reg[acc.addr[2:0]];
    end else begin
      acc.rdData <= UNMAPPED_VAL;
    end
  end

  assign cfgWord = {mem_reg[4], mem_reg[2], mem_reg[1], mem_reg[0]};

  a_unmapped_reads_ff : assert property (@(posedge clk) disable iff (!reset_n)
    acc.addr >= REG_LIMIT |=> acc.rdData == UNMAPPED_VAL)
    else $error("unmapped read did not return all ones");

endmodule : reg_bank

// ==== test/i2c_master_model.sv ====
module i2c_master_model (
  // bus lines, data is open drain
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter of the 64 ns link period
  localparam time Q = 16ns;

  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus conditions and bits
  // ----------------------------------------------------------------
  // also serves as repeated start; leaves the clock low
  task automatic start_cond();
    #Q;
    sdaLow = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sdaLow = 1'b1;
    #Q;
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #Q;
    sdaLow = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sdaLow = 1'b0;
    #Q;
  endtask : stop_cond

  // data moves only while the clock is low; read twice while high,
  // so a line that moves during the high phase reads as unknown
  task automatic bit_io(input logic b, output logic r);
    logic h;
    #Q;
    sdaLow = !b;
    #Q;
    scl = 1'b1;
    #Q;
    h = sda;
    #Q;
    r = (h === sda) ? h : 1'bx;
    scl = 1'b0;
  endtask : bit_io

  // eight bits msb first, then the slave's acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = (r === 1'b0);
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : get_byte
endmodule : i2c_master_model

// ==== test/tb_i2c_slave_register_port.sv ====
`define M i2c_master_model_i
`define CHK(got, exp) begin \
  checksDone++; \
  if ((got) !== (exp)) begin \
    nMismatch++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
  end \
end

module tb_i2c_slave_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_port_pkg::*;

  logic        clk;
  logic        reset_n;
  logic        scl;
  logic        sdaLow;
  logic        sdaOut;
  logic        sdaOe;
  logic        hsMode;
  logic [7:0]  statusIn;
  logic [31:0] cfgWord;
  wire  logic  sda;
  int          nMismatch;
  int          checksDone;
  logic [15:0] rnd;
  logic        ack;
  logic [7:0]  rd;
  logic [7:0]  expReg  [0:4] = '{RESET_REG0, RESET_REG1, RESET_REG2, 8'h00, RESET_REG4};
  logic [7:0]  idxList [7]   = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03, 8'h05, 8'h09};

  // released line floats high through the pull-up
  assign sda = (sdaLow || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;

  serial_reg_port serial_reg_port_i (
    .clk(clk), .reset_n(reset_n), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .statusIn(statusIn), .cfgWord(cfgWord), .hsMode(hsMode));
  i2c_master_model i2c_master_model_i (.scl(scl), .sdaLow(sdaLow), .sda(sda));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [7:0] exp_rd(input logic [7:0] idx);
    if (idx == 8'h03) return statusIn;
    if (idx < 8'h05) return expReg[idx[2:0]];
    return 8'hff;
  endfunction : exp_rd

  function automatic logic [31:0] exp_cfg();
    return {expReg[4], expReg[2], expReg[1], expReg[0]};
  endfunction : exp_cfg

  // old value must still stand at the acknowledge fall
  task automatic wr_pair(input logic [7:0] idx, input logic [7:0] d);
    `M.put_byte(idx, ack);
    `CHK(ack, 1'b1)
    `M.put_byte(d, ack);
    `CHK(ack, 1'b1)
    `CHK(cfgWord, exp_cfg())
    if (idx < 8'h05 && idx != 8'h03) expReg[idx[2:0]] = d;
    #48;
    `CHK(cfgWord, exp_cfg())
  endtask : wr_pair

  task automatic close_out();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #200us;
    nMismatch++;
    close_out();
  end

  initial begin
    reset_n    = 1'b0;
    statusIn   = 8'h00;
    rnd        = 16'hc22a;
    nMismatch  = 0;
    checksDone = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    // keeps every bus change clear of the clock edge
    #3;
    `CHK(cfgWord, 32'h0000_3040)
    `CHK(sdaOe, 1'b0)
    `CHK(hsMode, 1'b0)
    $display("test reset done");
    `M.start_cond();
    `M.put_byte(8'hd4, ack);
    `CHK(ack, 1'b1)
    foreach (idxList[k]) begin
      rnd = lfsr(rnd);
      wr_pair(idxList[k], rnd[7:0]);
    end
    `M.stop_cond();
    #48;
    `CHK(sdaOe, 1'b0)
    $display("test write done");
    rnd = lfsr(rnd);
    @(posedge clk);
    statusIn <= rnd[15:8];
    #3;
    `M.start_cond();
    `M.put_byte(8'hd4, ack);
    `M.put_byte(8'h00, ack);
    `M.start_cond();
    `M.put_byte(8'hd5, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < 6; i++) begin
      `M.get_byte(i == 5, rd);
      `CHK(rd, exp_rd(8'(i)))
    end
    `M.stop_cond();
    $display("test read done");
    for (int n = 0; n < 8; n++) begin
      rnd = lfsr(rnd);
      if (n == 0) rnd[7:1] = 7'h6b;
      if (rnd[7:1] == 7'h6a) rnd[1] = ~rnd[1];
      `M.start_cond();
      `M.put_byte({rnd[7:1], 1'b0}, ack);
      `CHK(ack, 1'b0)
      `M.put_byte(8'h00, ack);
      `CHK(ack, 1'b0)
      `M.stop_cond();
    end
    `CHK(cfgWord, exp_cfg())
    $display("test foreign address done");
    rnd = lfsr(rnd);
    `M.start_cond();
    `M.put_byte({5'b00001, rnd[2:0]}, ack);
    `CHK(ack, 1'b0)
    #48;
    `CHK(hsMode, 1'b1)
    `M.start_cond();
    `M.put_byte(8'hd4, ack);
    `CHK(ack, 1'b1)
    wr_pair(8'h01, rnd[15:8]);
    `M.start_cond();
    `M.put_byte(8'hd4, ack);
    `CHK(hsMode, 1'b1)
    wr_pair(8'h02, ~rnd[15:8]);
    `M.stop_cond();
    #48;
    `CHK(hsMode, 1'b0)
    $display("test high speed done");
    rnd = lfsr(rnd);
    `M.start_cond();
    `M.put_byte(8'hd4, ack);
    for (int b = 0; b < 3; b++) begin
      `M.bit_io(rnd[b], rd[0]);
    end
    `M.stop_cond();
    `M.start_cond();
    `M.put_byte(8'hd4, ack);
    `CHK(ack, 1'b1)
    wr_pair(8'h04, rnd[15:8]);
    `M.stop_cond();
    $display("test abort done");
    close_out();
  end
endmodule : tb_i2c_slave_register_port
